// >>> rtl/ccu_pkg.sv
package ccu_pkg;

   // widths of the timer, prescaler and pll divider
   localparam int TIMER_W = 16;
   localparam int PRESC_W = 10;
   localparam int PLLDIV_W = 4;
   localparam int NUM_CMP = 4;
   localparam int NUM_CAP = 2;
   localparam int NUM_FLAGS = 7;
   localparam int EVT_W = 4;

   // pll multiplier factor, unused: the pwm modes step at the divided reference rate
   localparam int PLL_MULT = 32;

   // timer terminal values
   localparam logic [15:0] TIMER_ZERO = 16'h0000;
   localparam logic [15:0] TIMER_ONE = 16'h0001;
   localparam logic [15:0] BYTE_MASK = 16'h00FF;
   localparam logic [PRESC_W-1:0] PRESC_TOP = 10'h3FF;
   localparam logic [PRESC_W-1:0] PRESC_RESET = 10'h3FF;
   localparam logic [3:0] PLLDIV_ZERO = 4'h0;

   // capture noise filter: samples of the new level needed
   localparam logic [2:0] FILTER_SAMPLES = 3'h4;

   // interrupt flag positions
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CAP0 = 1;
   localparam int FLAG_CMP0 = 3;

   // timer modes, one-hot
   typedef enum logic [2:0] {
      MODE_BASIC = 3'b001,
      MODE_ASYM = 3'b010,
      MODE_SYM = 3'b100
   } timer_mode_e;

endpackage : ccu_pkg

// >>> rtl/capture_if.sv
`timescale 1ns/1ps
// carries the running timer to a capture channel and its result back
interface capture_if;
   import ccu_pkg::*;
   logic [TIMER_W-1:0] timer_value;
   logic capture_strobe;
   logic [TIMER_W-1:0] capture_value;

   modport unit (output timer_value, input capture_strobe, capture_value);
   modport chan (input timer_value, output capture_strobe, capture_value);
endinterface : capture_if

// >>> rtl/capture_channel.sv
`timescale 1ns/1ps
module capture_channel
   import ccu_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic pin_in,
   input wire logic filter_en_in,
   input wire logic rising_sel_in,
   input wire logic [EVT_W-1:0] event_count_in,
   capture_if.chan cap
);

   logic sync1_reg; // first stage, read only by sync2
   logic sync2_reg;
   logic sync3_reg;
   logic level_reg; // accepted input level
   logic [2:0] agree_reg; // consecutive samples of the new level
   logic [EVT_W-1:0] evt_reg; // qualifying events so far
   logic edge_evt; // recognised edge of chosen sense
   logic accept;
   logic strobe_reg;
   logic [TIMER_W-1:0] value_reg;

   ////////////////////////////////////////////////////////////////////
   // three stage synchroniser
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // a new level counts only once stages two and three agree
   // four sample filter
   always_comb begin
      accept = 1'b0;
      if (sync2_reg == sync3_reg && sync3_reg != level_reg) begin
         accept = !filter_en_in || (agree_reg == FILTER_SAMPLES - 3'h1);
      end
   end

   // filter sample counter, restarts on any disagreement
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         agree_reg <= 3'h0;
      end else if (sync2_reg != sync3_reg || sync3_reg == level_reg) begin
         agree_reg <= 3'h0;
      end else if (!accept) begin
         agree_reg <= agree_reg + 3'h1;
      end else begin
         agree_reg <= 3'h0;
      end
   end

   // accepted level
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         level_reg <= 1'b0;
      end else if (accept) begin
         level_reg <= sync3_reg;
      end
   end

   assign edge_evt = accept && (sync3_reg == rising_sel_in);

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         evt_reg <= '0;
      end else if (edge_evt) begin
         evt_reg <= (evt_reg >= event_count_in) ? '0 : evt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         strobe_reg <= 1'b0;
         value_reg <= TIMER_ZERO;
      end else begin
         strobe_reg <= edge_evt && (evt_reg >= event_count_in);
         if (edge_evt && (evt_reg >= event_count_in)) begin
            value_reg <= cap.timer_value;
         end
      end
   end

   assign cap.capture_strobe = strobe_reg;
   assign cap.capture_value = value_reg;

   ////////////////////////////////////////////////////////////////////
   // copy holds event timer
   a_capture_copy: assert property (@(posedge core_clk_in)
      disable iff (reset_in) strobe_reg |-> value_reg == $past(cap.timer_value))
      else $error("capture value is not the timer at the event");

   a_filter_delay: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      (filter_en_in && $changed(level_reg)) |->
         $past(sync3_reg, 1) == level_reg && $past(sync3_reg, 4) == level_reg)
      else $error("filtered edge accepted too early");

   c_capture_seen: cover property (@(posedge core_clk_in)
      disable iff (reset_in) strobe_reg);

endmodule : capture_channel

// >>> rtl/capture_compare_unit.sv
`timescale 1ns/1ps
module capture_compare_unit
   import ccu_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic run_in,
   input wire timer_mode_e mode_in,
   input wire logic dir_up_in,
   input wire logic eight_bit_in,
   input wire logic alt_pairs_in,
   input wire logic [3:0] pll_input_divider_in,
   input wire logic [PRESC_W-1:0] presc_reload_in,
   input wire logic [TIMER_W-1:0] timer_reload_in,
   input wire logic [7:0] host_byte_in,
   input wire logic timer_hi_wr_in,
   input wire logic timer_lo_wr_in,
   input wire logic timer_lo_rd_in,
   output logic [7:0] timer_lo_out,
   output logic [7:0] timer_hi_out,
   input wire logic [TIMER_W-1:0] compare_a_in,
   input wire logic [TIMER_W-1:0] compare_b_in,
   input wire logic [TIMER_W-1:0] compare_c_in,
   input wire logic [TIMER_W-1:0] compare_d_in,
   input wire logic [NUM_CMP-1:0] chan_en_in,
   input wire logic [NUM_CMP-1:0] chan_pol_in,
   output logic [NUM_CMP-1:0] compare_pin_out,
   input wire logic [NUM_CAP-1:0] capture_pin_in,
   input wire logic [NUM_CAP-1:0] cap_filter_en_in,
   input wire logic [NUM_CAP-1:0] cap_rising_in,
   input wire logic [EVT_W-1:0] cap_event_count_in,
   output logic [TIMER_W-1:0] capture0_out,
   output logic [TIMER_W-1:0] capture1_out,
   input wire logic [NUM_FLAGS-1:0] irq_en_in,
   input wire logic [NUM_FLAGS-1:0] flag_clr_in,
   output logic [NUM_FLAGS-1:0] flags_out,
   output logic irq_out
);

   logic [3:0] pll_div_reg; // reference divider count
   logic unit_tick; // one pulse per unit timer clock
   logic [PRESC_W-1:0] presc_reg; // prescaler count
   logic presc_tick; // one pulse per timer step
   logic [TIMER_W-1:0] timer_reg; // main timer
   logic [TIMER_W-1:0] top; // reload value at current width
   logic count_up; // effective direction
   logic sym_up_reg; // symmetrical half in progress
   logic ovf_evt; // reload this cycle
   logic step_reg; // timer moved last cycle
   logic [7:0] wr_shadow_reg; // high byte awaiting low write
   logic [7:0] rd_shadow_reg; // high byte frozen at low read
   logic [TIMER_W-1:0] cmp_val [NUM_CMP];
   logic [NUM_CMP-1:0] match_evt; // compare events
   logic [NUM_CMP-1:0] output_halt_value_reg; // held pin levels
   logic [NUM_CMP-1:0] gate; // alternating pair gating
   logic alt_phase_reg; // which pair member is active
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_reg; // sticky interrupt flags
   logic [NUM_CMP-1:0] pin_reg;

   ////////////////////////////////////////////////////////////////////
   // unit clock selection
   // reference divider n plus one
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pll_div_reg <= PLLDIV_ZERO;
      end else if (pll_div_reg >= pll_input_divider_in) begin
         pll_div_reg <= PLLDIV_ZERO;
      end else begin
         pll_div_reg <= pll_div_reg + 4'h1;
      end
   end

   // clock source by mode, multiplier limit
   // the x32 multiplier cannot run above the core clock, so the pwm
   // modes step at the divided reference rate; ratios stay exact
   assign unit_tick = (mode_in == MODE_BASIC) ? 1'b1 :
                      (pll_div_reg >= pll_input_divider_in);

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         presc_reg <= PRESC_RESET;
      end else if (unit_tick) begin
         if (presc_reg == PRESC_TOP) begin
            presc_reg <= presc_reload_in;
         end else begin
            presc_reg <= presc_reg + 10'h001;
         end
      end
   end

   assign presc_tick = unit_tick && (presc_reg == PRESC_TOP) && run_in;
   ////////////////////////////////////////////////////////////////////
   // main timer
   // eight bit width option
   assign top = eight_bit_in ? (timer_reload_in & BYTE_MASK) :
                timer_reload_in;

   // direction at once, asym forces down
   always_comb begin
      case (mode_in)
         MODE_BASIC: count_up = dir_up_in;
         MODE_ASYM: count_up = 1'b0;
         MODE_SYM: count_up = sym_up_reg;
         default: count_up = dir_up_in;
      endcase
   end

   always_comb begin
      ovf_evt = 1'b0;
      if (presc_tick && !timer_lo_wr_in) begin
         if (mode_in == MODE_SYM) begin
            ovf_evt = !count_up && timer_reg == TIMER_ZERO;
         end else if (count_up) begin
            ovf_evt = timer_reg >= top;
         end else begin
            ovf_evt = timer_reg == TIMER_ZERO;
         end
      end
   end

   // host write wins, low byte commits both
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         timer_reg <= TIMER_ZERO;
      end else if (timer_lo_wr_in) begin
         timer_reg <= {wr_shadow_reg, host_byte_in};
      end else if (presc_tick) begin
         if (mode_in == MODE_SYM) begin
            if (count_up && timer_reg >= top) begin
               timer_reg <= timer_reg - TIMER_ONE;
            end else if (!count_up && timer_reg == TIMER_ZERO) begin
               timer_reg <= TIMER_ONE;
            end else if (count_up) begin
               timer_reg <= timer_reg + TIMER_ONE;
            end else begin
               timer_reg <= timer_reg - TIMER_ONE;
            end
         end else if (ovf_evt) begin
            timer_reg <= count_up ? TIMER_ZERO : top;
         end else if (count_up) begin
            timer_reg <= timer_reg + TIMER_ONE;
         end else begin
            timer_reg <= timer_reg - TIMER_ONE;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sym_up_reg <= 1'b1;
      end else if (mode_in != MODE_SYM) begin
         sym_up_reg <= 1'b1;
      end else if (presc_tick && !timer_lo_wr_in) begin
         if (sym_up_reg && timer_reg >= top) begin
            sym_up_reg <= 1'b0;
         end else if (!sym_up_reg && timer_reg == TIMER_ZERO) begin
            sym_up_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_shadow_reg <= 8'h00;
         rd_shadow_reg <= 8'h00;
      end else begin
         if (timer_hi_wr_in) begin
            wr_shadow_reg <= host_byte_in;
         end
         if (timer_lo_rd_in) begin
            rd_shadow_reg <= timer_reg[15:8];
         end
      end
   end

   assign timer_lo_out = timer_reg[7:0];
   assign timer_hi_out = rd_shadow_reg;

   // marks cycles in which the timer holds a freshly stepped value
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         step_reg <= 1'b0;
      end else begin
         step_reg <= presc_tick || timer_lo_wr_in;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // compare channels
   assign cmp_val[0] = compare_a_in;
   assign cmp_val[1] = compare_b_in;
   assign cmp_val[2] = compare_c_in;
   assign cmp_val[3] = compare_d_in;

   always_comb begin
      for (int i = 0; i < NUM_CMP; i++) begin
         match_evt[i] = step_reg && chan_en_in[i] &&
                        timer_reg == cmp_val[i];
      end
   end

   // level held, compare drives it
   // halt value keeps its level across enable so the pin never glitches
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         output_halt_value_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (match_evt[i]) begin
               case (mode_in)
                  MODE_BASIC: output_halt_value_reg[i] <=
                                 !output_halt_value_reg[i];
                  MODE_ASYM: output_halt_value_reg[i] <= 1'b1;
                  MODE_SYM: output_halt_value_reg[i] <= !sym_up_reg;
                  default: output_halt_value_reg[i] <=
                              output_halt_value_reg[i];
               endcase
            end else if (ovf_evt && mode_in == MODE_ASYM &&
                         chan_en_in[i]) begin
               output_halt_value_reg[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         alt_phase_reg <= 1'b0;
      end else if (ovf_evt) begin
         alt_phase_reg <= !alt_phase_reg;
      end
   end

   // alternate gating of a/b and c/d
   always_comb begin
      gate = '1;
      if (alt_pairs_in && mode_in == MODE_ASYM) begin
         gate = alt_phase_reg ? 4'b1010 : 4'b0101;
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pin_reg <= '0;
      end else begin
         pin_reg <= (output_halt_value_reg & gate) ^ chan_pol_in;
      end
   end

   assign compare_pin_out = pin_reg;
   ////////////////////////////////////////////////////////////////////
   // capture channels
   capture_if cap_bus [NUM_CAP] ();
   generate
      for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
         assign cap_bus[c].timer_value = timer_reg;
         capture_channel u_cap (
            .core_clk_in(core_clk_in),
            .reset_in(reset_in),
            .pin_in(capture_pin_in[c]),
            .filter_en_in(cap_filter_en_in[c]),
            .rising_sel_in(cap_rising_in[c]),
            .event_count_in(cap_event_count_in),
            .cap(cap_bus[c])
         );
         assign flag_set[FLAG_CAP0 + c] = cap_bus[c].capture_strobe;
      end
   endgenerate

   assign capture0_out = cap_bus[0].capture_value;
   assign capture1_out = cap_bus[1].capture_value;
   ////////////////////////////////////////////////////////////////////
   // interrupt flags
   // reload raises overflow flag
   assign flag_set[FLAG_OVF] = ovf_evt;
   assign flag_set[FLAG_CMP0 +: NUM_CMP] = match_evt;

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= (flag_reg & ~flag_clr_in) | flag_set;
      end
   end

   assign irq_out = |(flag_reg & irq_en_in);
   assign flags_out = flag_reg;
   ////////////////////////////////////////////////////////////////////
   // checks
   a_irq_or: assert property (@(posedge core_clk_in)
      disable iff (reset_in) irq_out == |(flags_out & irq_en_in))
      else $error("request differs from enabled flags");
   a_flag_sticky: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      (flag_reg[FLAG_OVF] && !flag_clr_in[FLAG_OVF]) |=> flag_reg[FLAG_OVF])
      else $error("overflow flag dropped without clear");
   a_ovf_flag: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      ovf_evt |=> flag_reg[FLAG_OVF])
      else $error("reload did not set overflow flag");
   a_down_reload: assert property (@(posedge core_clk_in)
      disable iff (reset_in) (ovf_evt && !count_up && mode_in != MODE_SYM)
      |=> timer_reg == $past(top))
      else $error("down count did not reload");
   a_asym_down: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      (presc_tick && mode_in == MODE_ASYM && !timer_lo_wr_in &&
       timer_reg != TIMER_ZERO) |=> timer_reg == $past(timer_reg) - TIMER_ONE)
      else $error("asymmetrical mode did not count down");
   a_presc_ratio: assert property (@(posedge core_clk_in)
      disable iff (reset_in) (unit_tick && presc_reg == PRESC_TOP)
      |=> presc_reg == $past(presc_reload_in))
      else $error("prescaler did not reload");
   a_match_flag: assert property (@(posedge core_clk_in)
      disable iff (reset_in) (step_reg && chan_en_in[0] &&
      timer_reg == compare_a_in) |=> flag_reg[FLAG_CMP0])
      else $error("compare match flag not set");
   a_halt_hold: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      (!chan_en_in[1] && !ovf_evt) |=> $stable(output_halt_value_reg[1]))
      else $error("disabled channel level moved");
   a_polarity: assert property (@(posedge core_clk_in)
      disable iff (reset_in)
      1'b1 |=> compare_pin_out == (($past(output_halt_value_reg) & $past(gate))
                                   ^ $past(chan_pol_in)))
      else $error("pin does not follow polarity");
   c_sym_turn: cover property (@(posedge core_clk_in) disable iff (reset_in)
      mode_in == MODE_SYM && $fell(sym_up_reg));
   c_alt_pair: cover property (@(posedge core_clk_in) disable iff (reset_in)
      alt_pairs_in && mode_in == MODE_ASYM && $rose(alt_phase_reg));
   c_irq: cover property (@(posedge core_clk_in) disable iff (reset_in)
      $rose(irq_out));

endmodule : capture_compare_unit

// >>> tb/capture_source.sv
`timescale 1ns/1ps
// far-side model: drives the two capture pins
module capture_source (
   input wire logic core_clk_in,
   output logic [1:0] pins_out
);
   // pins idle low until a scenario asks for an edge
   initial pins_out = 2'h0;
   // edges and glitches on demand
   // changes land off the sampling edge, so no race with the sync flops
   task automatic drive_level(input int ch, input logic lvl, input int n);
      @(negedge core_clk_in);
      pins_out[ch] = lvl;
      repeat (n) @(negedge core_clk_in);
   endtask : drive_level
endmodule : capture_source

// >>> tb/capture_compare_unit_tb.sv
`timescale 1ns/1ps
module capture_compare_unit_tb;
   import ccu_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic run_in = 1'b0, dir_up_in = 1'b1, eight_bit_in = 1'b0;
   logic alt_pairs_in = 1'b0;
   timer_mode_e mode_in = MODE_BASIC;
   logic [3:0] pll_input_divider_in = 4'h0;
   logic [PRESC_W-1:0] presc_reload_in = 10'h3FF;
   logic [15:0] timer_reload_in = 16'hFFFF;
   logic [7:0] host_byte_in = 8'h00;
   logic timer_hi_wr_in = 1'b0, timer_lo_wr_in = 1'b0, timer_lo_rd_in = 1'b0;
   logic [7:0] timer_lo_out, timer_hi_out;
   logic [15:0] compare_a_in = 16'h0004, compare_b_in = 16'h0004;
   logic [15:0] compare_c_in = 16'hF000, compare_d_in = 16'hF000;
   logic [3:0] chan_en_in = 4'h0, chan_pol_in = 4'h0, compare_pin_out;
   wire logic [1:0] capture_pin_in;
   logic [1:0] cap_filter_en_in = 2'h0, cap_rising_in = 2'h1;
   logic [3:0] cap_event_count_in = 4'h0;
   logic [15:0] capture0_out, capture1_out;
   logic [6:0] irq_en_in = 7'h00, flag_clr_in = 7'h00, flags_out;
   logic irq_out;
   int error_cnt = 0, checked = 0;
   logic [7:0] a;

   capture_compare_unit dut_u (.core_clk_in, .reset_in, .run_in, .mode_in,
      .dir_up_in, .eight_bit_in, .alt_pairs_in, .pll_input_divider_in,
      .presc_reload_in, .timer_reload_in, .host_byte_in, .timer_hi_wr_in,
      .timer_lo_wr_in, .timer_lo_rd_in, .timer_lo_out, .timer_hi_out,
      .compare_a_in, .compare_b_in, .compare_c_in, .compare_d_in,
      .chan_en_in, .chan_pol_in, .compare_pin_out, .capture_pin_in,
      .cap_filter_en_in, .cap_rising_in, .cap_event_count_in, .capture0_out,
      .capture1_out, .irq_en_in, .flag_clr_in, .flags_out, .irq_out);
   capture_source pin_u (.core_clk_in, .pins_out(capture_pin_in));

   ////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial forever #25 core_clk_in = ~core_clk_in;

   // one comparison, reported and counted at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask : cyc
   // high byte into the shadow first, the low byte commits both
   task automatic wr_timer(input logic [15:0] v);
      host_byte_in = v[15:8];
      timer_hi_wr_in = 1'b1;
      cyc(1);
      timer_hi_wr_in = 1'b0;
      host_byte_in = v[7:0];
      timer_lo_wr_in = 1'b1;
      cyc(1);
      timer_lo_wr_in = 1'b0;
      cyc(1);
   endtask : wr_timer
   // reading low freezes the high byte for the second access
   task automatic rd_hi();
      timer_lo_rd_in = 1'b1;
      cyc(1);
      timer_lo_rd_in = 1'b0;
      cyc(1);
   endtask : rd_hi
   task automatic clr_flags();
      flag_clr_in = 7'h7F;
      cyc(1);
      flag_clr_in = 7'h00;
      cyc(1);
   endtask : clr_flags
   task automatic run_for(input int n);
      run_in = 1'b1;
      cyc(n);
      run_in = 1'b0;
      cyc(2);
   endtask : run_for

   ////////////////////////////////////////////////////////////////////////
   // coherent byte access, stopped and while counting
   task automatic t_shadow();
      wr_timer(16'h1234);
      chk(timer_lo_out, 16'h0034);
      rd_hi();
      chk(timer_hi_out, 16'h0012);
      run_in = 1'b1;
      wr_timer(16'h5600);
      run_in = 1'b0;
      rd_hi();
      chk(timer_hi_out, 16'h0056);
   endtask : t_shadow
   // reload at top, sticky flag, request gating, 8-bit width
   task automatic t_ovf();
      timer_reload_in = 16'h0005;
      wr_timer(16'h0003);
      clr_flags();
      irq_en_in = 7'h01;
      run_for(20);
      chk({15'h0, timer_lo_out <= 8'h05}, 16'h0001);
      chk(flags_out, 16'h0001);
      chk(irq_out, 16'h0001);
      irq_en_in = 7'h00;
      cyc(1);
      chk(irq_out, 16'h0000);
      clr_flags();
      chk(flags_out, 16'h0000);
      eight_bit_in = 1'b1;
      timer_reload_in = 16'h0305;
      wr_timer(16'h0000);
      run_for(20);
      chk({15'h0, timer_lo_out <= 8'h05}, 16'h0001);
      eight_bit_in = 1'b0;
   endtask : t_ovf
   // ratio 3 slows the count to about a third
   task automatic t_presc();
      timer_reload_in = 16'hFFFF;
      presc_reload_in = 10'h3FD;
      wr_timer(16'h0000);
      run_for(30);
      a = timer_lo_out;
      chk({15'h0, a >= 8'h08 && a <= 8'h0B}, 16'h0001);
      presc_reload_in = 10'h3FF;
   endtask : t_presc
   // basic down, and asymmetric which ignores the direction bit
   task automatic t_down(input timer_mode_e m, input logic up);
      mode_in = m;
      dir_up_in = up;
      wr_timer(16'h0180);
      run_for(5);
      a = timer_lo_out;
      chk({15'h0, a >= 8'h70 && a <= 8'h7F}, 16'h0001);
      mode_in = MODE_BASIC;
      dir_up_in = 1'b1;
   endtask : t_down
   // symmetric: past the top the count falls
   task automatic t_sym();
      mode_in = MODE_SYM;
      timer_reload_in = 16'h0020;
      wr_timer(16'h001C);
      run_in = 1'b1;
      cyc(11);
      a = timer_lo_out;
      cyc(2);
      run_in = 1'b0;
      chk({15'h0, timer_lo_out < a && a <= 8'h20}, 16'h0001);
      mode_in = MODE_BASIC;
   endtask : t_sym
   // A enabled and B disabled share one match value
   task automatic t_cmp();
      timer_reload_in = 16'h0010;
      wr_timer(16'h0000);
      clr_flags();
      chan_en_in = 4'h1;
      run_for(8);
      chk(flags_out, 16'h0008);
      chk(compare_pin_out, 16'h0001);
      chan_pol_in = 4'h1;
      cyc(3);
      chk(compare_pin_out, 16'h0000);
      chan_pol_in = 4'h0;
      chan_en_in = 4'h0;
   endtask : t_cmp
   // asym pwm at clock/(n+1), pair A/B gated on alternately
   task automatic t_pwm();
      int a_hi = 0, b_hi = 0, both = 0;
      mode_in = MODE_ASYM;
      pll_input_divider_in = 4'h1;
      wr_timer(16'h0100);
      run_for(20);
      a = timer_lo_out;
      chk({15'h0, a >= 8'hF4 && a <= 8'hF8}, 16'h0001);
      timer_reload_in = 16'h0007;
      wr_timer(16'h0007);
      chan_en_in = 4'h3;
      alt_pairs_in = 1'b1;
      run_in = 1'b1;
      repeat (64) begin
         cyc(1);
         a_hi += compare_pin_out[0];
         b_hi += compare_pin_out[1];
         both += compare_pin_out[0] & compare_pin_out[1];
      end
      run_in = 1'b0;
      chk(both[15:0], 16'h0000);
      chk({15'h0, a_hi > 0}, 16'h0001);
      chk({15'h0, b_hi > 0}, 16'h0001);
      chan_en_in = 4'h0;
      alt_pairs_in = 1'b0;
      mode_in = MODE_BASIC;
      pll_input_divider_in = 4'h0;
   endtask : t_pwm
   // stopped timer makes the captured value exact
   task automatic t_cap();
      wr_timer(16'hABCD);
      clr_flags();
      pin_u.drive_level(0, 1'b1, 10);
      chk(capture0_out, 16'hABCD);
      pin_u.drive_level(1, 1'b1, 10);
      chk(flags_out, 16'h0002);
      pin_u.drive_level(1, 1'b0, 10);
      chk(capture1_out, 16'hABCD);
      pin_u.drive_level(0, 1'b0, 4);
      clr_flags();
      cap_filter_en_in = 2'h1;
      pin_u.drive_level(0, 1'b1, 2);
      pin_u.drive_level(0, 1'b0, 12);
      chk(flags_out, 16'h0000);
      pin_u.drive_level(0, 1'b1, 14);
      chk(flags_out, 16'h0002);
      cap_filter_en_in = 2'h0;
      cap_event_count_in = 4'h1;
      pin_u.drive_level(0, 1'b0, 4);
      clr_flags();
      pin_u.drive_level(0, 1'b1, 10);
      chk(flags_out, 16'h0000);
      pin_u.drive_level(0, 1'b0, 4);
      pin_u.drive_level(0, 1'b1, 10);
      chk(flags_out, 16'h0002);
   endtask : t_cap

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // hang guard: the whole sequence needs well under 2000 cycles
   initial begin
      #(50 * 20000);
      error_cnt++;
      summarize();
   end

   initial begin
      cyc(16);
      reset_in = 1'b0;
      t_shadow();
      t_ovf();
      t_presc();
      t_down(MODE_BASIC, 1'b0);
      t_down(MODE_ASYM, 1'b1);
      t_sym();
      t_cmp();
      t_pwm();
      t_cap();
      summarize();
   end
endmodule : capture_compare_unit_tb
